// ### tb/ssr_checker.sv
`timescale 1ns/1ns

module ssr_checker
	import ssr_pkg::*;
#(
	parameter int ADDR_W = 10,
	parameter bit DOWNSTREAM = 1'b1,
	parameter bit ARI_SUPPORT = 1'b1
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Register port
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	// Expander, config and interrupt
	input wire logic exp_req,
	input wire logic [15:0] exp_ctl,
	input wire logic exp_done,
	input wire logic [4:0] cfg_dev_num,
	input wire logic cfg_dev_ok,
	input wire logic skip_devnum_check,
	input wire logic hotplug_irq
);
	// Slot control write that landed while a transaction was open
	logic more_q;
	always_ff @(posedge clk) begin
		if (!rstn) begin
			more_q <= 1'b0;
		end else if (exp_req && exp_done) begin
			more_q <= 1'b0;
		end else if (reg_wr && reg_addr == 'h160 && exp_req) begin
			more_q <= 1'b1;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	AST_RD_UPPER: assert property (reg_rdata[31:16] == 16'h0000)
		else $error("read data upper half not zero");
	AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
		else $error("read data outside read slot");
	AST_STS_RSVD: assert property (reg_rd && reg_addr == 'h168 |=> reg_rdata[15:9] == 7'h00)
		else $error("slot status reserved bits set");
	AST_DSTS2: assert property (reg_rd && reg_addr == 'h1a8 |=> reg_rdata == 32'h0000_0000)
		else $error("device status two not zero");
	AST_CAP: assert property (reg_rd && reg_addr == 'h190 |=>
		reg_rdata == {26'h0, DOWNSTREAM && ARI_SUPPORT, 5'h00}) else $error("capability wrong");
	AST_CTL_IMAGE: assert property (reg_wr && reg_addr == 'h160 |=>
		(exp_ctl & 16'h17ff) == ($past(reg_wdata[15:0]) & 16'h17ff)) else $error("ctl image");
	AST_CMD_START: assert property (reg_wr && reg_addr == 'h160 && reg_wdata[11] && !exp_req
		&& !$past(exp_req) && !$past(reg_wr) && !$past(reg_wr, 2) |=> exp_req)
		else $error("command did not open a transaction");
	AST_REQ_HOLD: assert property (exp_req && !exp_done |=> exp_req)
		else $error("transaction dropped early");
	AST_REQ_CLOSE: assert property (exp_req && exp_done && !more_q
		&& !(reg_wr && reg_addr == 'h160) |=> !exp_req)
		else $error("transaction not closed");
	AST_IRQ_MASTER: assert property (hotplug_irq |-> exp_ctl[5])
		else $error("interrupt without master enable");
	AST_DEV_OK: assert property (cfg_dev_ok == (skip_devnum_check || cfg_dev_num == 5'h00))
		else $error("device number check wrong");
	AST_SKIP_SET: assert property (reg_wr && reg_addr == 'h1a0 |=>
		skip_devnum_check == (DOWNSTREAM && ARI_SUPPORT && $past(reg_wdata[5])))
		else $error("forwarding enable wrong");

	// Main scenarios
	cover property (exp_req && exp_done);
	cover property (hotplug_irq);
	cover property (exp_req && exp_done && more_q ##1 exp_req);
	cover property (reg_rd && reg_addr == 'h168 ##1 reg_rdata[4]);
endmodule // ssr_checker

// ### tb/ssr_exp_model.sv
`timescale 1ns/1ns

module ssr_exp_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Expander handshake
	input wire logic exp_req,
	input wire logic [3:0] lat,
	output logic exp_done
);
	logic [3:0] cnt_q;
	// Finish each open transaction after lat plus one busy cycles with a one-cycle pulse
	always_ff @(posedge clk) begin
		if (!rstn || !exp_req || exp_done) begin
			cnt_q <= 4'h0;
			exp_done <= 1'b0;
		end else if (cnt_q >= lat) begin
			exp_done <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 4'h1;
		end
	end
endmodule // ssr_exp_model

// ### tb/tb_slot_status_ari_forwarding_regs.sv
`timescale 1ns/1ns

module tb_slot_status_ari_forwarding_regs
	import ssr_pkg::*;
();
	logic clk, rstn, reg_wr, reg_rd, button_pin, power_fault_pin, retention_latch_pin;
	logic presence_pin, interlock_pin, link_active_indication, exp_req, exp_done;
	logic cfg_dev_ok, skip_devnum_check, hotplug_irq;
	logic [9:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, rv;
	ssr_half_t exp_ctl;
	logic [4:0] cfg_dev_num;
	logic [3:0] exp_lat;
	logic [8:0] evf, c;
	logic [9:0] ra [8] = '{10'h168, 10'h160, 10'h190, 10'h1a0, 10'h1a8, 10'h200, 10'h204, 10'h3fc};
	ssr_half_t rvv [8] = '{16'h0040, 16'h01c0, 16'h0020, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0};
	int err_count, n_compared, n_done, i;

	// Clock and instances
	always #10 clk = ~clk;
	ssr_regs dut (.clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .button_pin,
		.power_fault_pin, .retention_latch_pin, .presence_pin, .interlock_pin,
		.link_active_indication, .exp_req, .exp_ctl, .exp_done, .cfg_dev_num, .cfg_dev_ok,
		.skip_devnum_check, .hotplug_irq);
	ssr_exp_model model (.clk, .rstn, .exp_req, .lat(exp_lat), .exp_done);
	always @(posedge clk) if (exp_done === 1'b1) n_done++;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task tally_and_finish;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task tick;
		@(posedge clk);
		#1;
	endtask
	task wr(input logic [9:0] a, input ssr_half_t d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= {16'h0000, d};
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task rdc(input logic [9:0] a, input logic [31:0] exp);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, exp);
	endtask
	task guard(input bit ok);
		if (!ok) begin
			err_count++;
			$display("wait ran out at %0t", $time);
			tally_and_finish();
		end
	endtask
	function automatic logic [31:0] sts_exp();
		return {23'h0, evf[8], interlock_pin, presence_pin, retention_latch_pin, evf[4:0]};
	endfunction
	// Raise one slot event, then let the sync chains settle
	task evt(input int k);
		@(posedge clk);
		case (k)
			0: button_pin <= 1'b1;
			1: power_fault_pin <= 1'b1;
			2: retention_latch_pin <= ~retention_latch_pin;
			3: presence_pin <= ~presence_pin;
			default: link_active_indication <= ~link_active_indication;
		endcase
		interlock_pin <= 1'($urandom);
		evf[(k == 4) ? 8 : k] = 1'b1;
		repeat (5) @(posedge clk);
		button_pin <= 1'b0;
		power_fault_pin <= 1'b0;
		repeat (5) @(posedge clk);
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{clk, rstn, reg_wr, reg_rd, button_pin, power_fault_pin, retention_latch_pin} = '0;
		{interlock_pin, link_active_indication, reg_addr, reg_wdata, cfg_dev_num, evf} = '0;
		presence_pin = 1'b1;
		exp_lat = 4'h3;
		void'($urandom(63160));
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		for (i = 0; i < 8; i++) rdc(ra[i], {16'h0, rvv[i]});
		$display("reset value test done");
		repeat (25) begin
			evt($urandom_range(4));
			rdc(10'h168, sts_exp());
			c = 9'($urandom);
			wr($urandom_range(1) ? 10'h168 : 10'h204, {7'h7f, c[8], 3'h7, c[4:0]});
			evf = evf & ~c;
			rdc(10'h168, sts_exp());
		end
		$display("event flag test done");
		wr(10'h168, 16'h011f);
		evf = '0;
		wr(10'h200, 16'h011f);
		rdc(10'h200, 32'h0000_011f);
		wr(10'h160, 16'h01e0);
		repeat (3) tick();
		chk({31'h0, hotplug_irq}, 32'h1);
		wr(10'h204, 16'h0010);
		tick();
		chk({31'h0, hotplug_irq}, 32'h0);
		wr(10'h200, 16'h0000);
		evt(0);
		chk({31'h0, hotplug_irq}, 32'h0);
		wr(10'h200, 16'h0001);
		tick();
		chk({31'h0, hotplug_irq}, 32'h1);
		wr(10'h160, 16'h01c0);
		repeat (3) tick();
		chk({31'h0, hotplug_irq}, 32'h0);
		wr(10'h168, 16'h011f);
		evf = '0;
		$display("interrupt test done");
		exp_lat <= 4'hc;
		n_done = 0;
		wr(10'h160, 16'h0040);
		for (i = 0; i < 50 && exp_req !== 1'b1; i++) tick();
		guard(exp_req === 1'b1);
		chk({16'h0, exp_ctl}, 32'h0000_0040);
		wr(10'h160, 16'h0880);
		rdc(10'h168, sts_exp());
		for (i = 0; i < 200 && n_done < 2; i++) tick();
		guard(n_done == 2);
		repeat (3) tick();
		evf[4] = 1'b1;
		rdc(10'h168, sts_exp());
		wr(10'h204, 16'h0010);
		evf[4] = 1'b0;
		repeat (20) tick();
		rdc(10'h168, sts_exp());
		rdc(10'h160, 32'h0000_0080);
		wr(10'h160, 16'h0880);
		n_done = 0;
		tick();
		chk({16'h0, exp_ctl}, 32'h0000_0880);
		for (i = 0; i < 200 && n_done < 1; i++) tick();
		guard(n_done == 1);
		repeat (3) tick();
		rdc(10'h168, sts_exp() | 32'h0000_0010);
		wr(10'h204, 16'h0010);
		$display("command test done");
		wr(10'h1a0, 16'hffff);
		rdc(10'h1a0, 32'h0000_0020);
		chk({31'h0, skip_devnum_check}, 32'h1);
		rv = 32'h0000_0001;
		repeat (2) begin
			repeat (6) begin
				@(posedge clk);
				cfg_dev_num <= 5'($urandom);
				tick();
				chk({31'h0, cfg_dev_ok}, {31'h0, rv[0] | cfg_dev_num == 5'h0});
			end
			wr(10'h1a0, 16'h0000);
			rv = 32'h0000_0000;
			tick();
		end
		chk({31'h0, skip_devnum_check}, 32'h0);
		wr(10'h190, 16'h0000);
		rdc(10'h190, 32'h0000_0020);
		wr(10'h1a8, 16'hffff);
		rdc(10'h1a8, 32'h0000_0000);
		$display("forwarding test done");
		tally_and_finish();
	end
endmodule // tb_slot_status_ari_forwarding_regs

bind ssr_regs ssr_checker #(.ADDR_W(ADDR_W), .DOWNSTREAM(DOWNSTREAM), .ARI_SUPPORT(ARI_SUPPORT))
	u_chk (.clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .exp_req,
	.exp_ctl, .exp_done, .cfg_dev_num, .cfg_dev_ok, .skip_devnum_check, .hotplug_irq);

// ### verilog/ssr_cmd_tracker.sv
`timescale 1ns/1ns
`include "ssr_params.svh"

module ssr_cmd_tracker
	import ssr_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Command side
	input wire logic start,
	input wire logic need_xact,
	output logic cmd_done,
	output logic busy,
	// I/O expander transaction side
	output logic exp_req,
	input wire logic exp_done
);

	ssr_cmd_state_t state_q;
	logic again_q;

	// --------------------------------
	// Sequencer
	// --------------------------------
	// A command finishes only after its expander transaction ends
	always_ff @(posedge clk) begin
		if (!rstn) begin
			state_q <= SSR_IDLE;
		end else begin
			case (state_q)
				SSR_IDLE: begin
					if (start) begin
						state_q <= need_xact ? SSR_ISSUE : SSR_DONE;
					end
				end
				SSR_ISSUE: begin
					state_q <= SSR_WAIT;
				end
				SSR_WAIT: begin
					if (exp_done) begin
						state_q <= (again_q || start) ? SSR_ISSUE : SSR_DONE;
					end
				end
				SSR_DONE: begin
					state_q <= start ? (need_xact ? SSR_ISSUE : SSR_DONE) : SSR_IDLE;
				end
				default: begin
					state_q <= SSR_IDLE;
				end
			endcase
		end
	end

	// Remember a write that arrives while a transaction is open
	always_ff @(posedge clk) begin
		if (!rstn) begin
			again_q <= 1'b0;
		end else if (start && (state_q == SSR_ISSUE || state_q == SSR_WAIT)) begin
			again_q <= 1'b1;
		end else if (state_q == SSR_ISSUE) begin
			again_q <= 1'b0;
		end
	end

	// Outputs
	assign exp_req = (state_q == SSR_ISSUE) || (state_q == SSR_WAIT);
	assign cmd_done = (state_q == SSR_DONE);
	assign busy = (state_q != SSR_IDLE);

endmodule // ssr_cmd_tracker

// ### verilog/ssr_params.svh
`ifndef SSR_PARAMS_SVH
`define SSR_PARAMS_SVH

// ----------------------------------------
// Register indices (byte address = index * 4)
// ----------------------------------------
`define SSR_IDX_SLOT_CTL 8'h58
`define SSR_IDX_SLOT_STS 8'h5a
`define SSR_IDX_DEV_CAP2 8'h64
`define SSR_IDX_DEV_CTL2 8'h68
`define SSR_IDX_DEV_STS2 8'h6a
`define SSR_IDX_IRQ_EN 8'h80
`define SSR_IDX_IRQ_CLR 8'h81

// ----------------------------------------
// Slot status fields
// ----------------------------------------
`define SSR_STS_BUTTON 0
`define SSR_STS_PFAULT 1
`define SSR_STS_LATCH_CHG 2
`define SSR_STS_PRES_CHG 3
`define SSR_STS_CMD_DONE 4
`define SSR_STS_LATCH 5
`define SSR_STS_PRESENCE 6
`define SSR_STS_INTERLOCK 7
`define SSR_STS_LINK_CHG 8
`define SSR_EVT_MASK 16'h011f

// ----------------------------------------
// Slot control, capability and control fields
// ----------------------------------------
`define SSR_CTL_MASTER_EN 5
`define SSR_CTL_ACT_LO 6
`define SSR_CTL_ACT_HI 11
`define SSR_CTL_INTERLOCK 11
`define SSR_CTL_LINK_EN 12
`define SSR_CTL_MASK 16'h1fff
`define SSR_ARI_BIT 5

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SSR_RST_SLOT_CTL 16'h01c0
`define SSR_RST_IRQ_EN 16'h0000
`define SSR_RST_LATCH 1'b0
`define SSR_RST_PRESENCE 1'b1

`endif

// ### verilog/ssr_pkg.sv
package ssr_pkg;

	// Command tracker states
	typedef enum logic [1:0] {
		SSR_IDLE,
		SSR_ISSUE,
		SSR_WAIT,
		SSR_DONE
	} ssr_cmd_state_t;

	// Register data word
	typedef logic [15:0] ssr_half_t;

endpackage

// ### verilog/ssr_regs.sv
// Strobed register access was decided locally.
`timescale 1ns/1ns
`include "ssr_params.svh"

// Summary of operation
// - Button press sets status bit 0
// - Power fault sets status bit 1
// - Latch sensor change sets bit 2
// - Presence change sets bit 3
// - Command completion sets sticky bit 4
// - Slot control writes during an open transaction join that command
// - Completion waits for all expander transactions
// - Live latch state read at bit 5
// - Card presence read at bit 6, reset one
// - Interlock state read at bit 7
// - Link active toggle sets bit 8
// - Forwarding supported bit 5 on downstream only
// - Forwarding enable skips device-number-zero check
// - Enable reads zero without forwarding support
// - Upstream port enable reads zero, ignores writes
// - Interrupt needs master hot-plug enable bit 5

module ssr_regs
	import ssr_pkg::*;
#(
	parameter bit DOWNSTREAM = 1'b1,
	parameter bit ARI_SUPPORT = 1'b1,
	parameter bit HAS_INTERLOCK = 1'b1,
	parameter int ADDR_W = 10
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Register port
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// Slot pins
	input wire logic button_pin,
	input wire logic power_fault_pin,
	input wire logic retention_latch_pin,
	input wire logic presence_pin,
	input wire logic interlock_pin,
	// Link layer, same clock
	input wire logic link_active_indication,
	// I/O expander transactions
	output logic exp_req,
	output logic [15:0] exp_ctl,
	input wire logic exp_done,
	// Configuration request conversion
	input wire logic [4:0] cfg_dev_num,
	output logic cfg_dev_ok,
	output logic skip_devnum_check,
	// Interrupt
	output logic hotplug_irq
);

	// ----------------------------------------
	// Elaboration check
	// ----------------------------------------
	// Refuses an address bus too narrow or too wide for the map
	if (ADDR_W < 10 || ADDR_W > 16) begin : g_addr_w_check
		$error("ssr_regs: ADDR_W must lie in 10..16");
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Matches a byte address against a register index
	function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [7:0] idx);
		hit = (addr == ADDR_W'({idx, 2'b00}));
	endfunction

	// Two flip-flop synchroniser chain update
	function automatic logic [1:0] sync2(input logic [1:0] chain, input logic pin);
		sync2 = {chain[0], pin};
	endfunction

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic [1:0] btn_sync_q;
	logic [1:0] pf_sync_q;
	logic [1:0] latch_sync_q;
	logic [1:0] pres_sync_q;
	logic [1:0] ilk_sync_q;
	logic btn_prev_q;
	logic pf_prev_q;
	logic latch_state_q;
	logic card_presence_state_q;
	logic interlock_state_q;
	logic link_prev_q;
	logic button_pressed_flag_q;
	logic power_fault_flag_q;
	logic latch_sensor_changed_flag_q;
	logic presence_changed_flag_q;
	logic cmd_done_flag_q;
	logic link_active_changed_flag_q;
	ssr_half_t slot_control_q;
	ssr_half_t slot_control_d;
	ssr_half_t irq_en_q;
	logic alt_routing_forward_enable_q;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	ssr_half_t status_w;
	ssr_half_t clr_w;
	logic wr_ctl;
	logic wr_sts;
	logic wr_clr;
	logic ev_button;
	logic ev_pfault;
	logic ev_latch;
	logic ev_pres;
	logic ev_link;
	logic cmd_done;
	logic need_xact;
	logic alt_routing_forward_supported;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	// Every slot pin passes two flip-flops before use
	always_ff @(posedge clk) begin
		if (!rstn) begin
			btn_sync_q <= 2'b00;
			pf_sync_q <= 2'b00;
			latch_sync_q <= {2{`SSR_RST_LATCH}};
			pres_sync_q <= {2{`SSR_RST_PRESENCE}};
			ilk_sync_q <= 2'b00;
		end else begin
			btn_sync_q <= sync2(btn_sync_q, button_pin);
			pf_sync_q <= sync2(pf_sync_q, power_fault_pin);
			latch_sync_q <= sync2(latch_sync_q, retention_latch_pin);
			pres_sync_q <= sync2(pres_sync_q, presence_pin);
			ilk_sync_q <= sync2(ilk_sync_q, interlock_pin);
		end
	end

	// Observed states, one cycle behind the synchronised level or the link indication
	always_ff @(posedge clk) begin
		if (!rstn) begin
			btn_prev_q <= 1'b0;
			pf_prev_q <= 1'b0;
			latch_state_q <= `SSR_RST_LATCH;
			card_presence_state_q <= `SSR_RST_PRESENCE;
			interlock_state_q <= 1'b0;
			link_prev_q <= 1'b0;
		end else begin
			btn_prev_q <= btn_sync_q[1];
			pf_prev_q <= pf_sync_q[1];
			latch_state_q <= latch_sync_q[1];
			card_presence_state_q <= pres_sync_q[1];
			interlock_state_q <= HAS_INTERLOCK & ilk_sync_q[1];
			link_prev_q <= link_active_indication;
		end
	end

	// ----------------------------------------
	// Event detection
	// ----------------------------------------
	// Press and fault are rising edges; the rest are any change
	assign ev_button = btn_sync_q[1] & ~btn_prev_q;
	assign ev_pfault = pf_sync_q[1] & ~pf_prev_q;
	assign ev_latch = latch_sync_q[1] ^ latch_state_q;
	assign ev_pres = pres_sync_q[1] ^ card_presence_state_q;
	assign ev_link = link_active_indication ^ link_prev_q;

	// ----------------------------------------
	// Register decode
	// ----------------------------------------
	assign wr_ctl = reg_wr & hit(reg_addr, `SSR_IDX_SLOT_CTL);
	assign wr_sts = reg_wr & hit(reg_addr, `SSR_IDX_SLOT_STS);
	assign wr_clr = reg_wr & hit(reg_addr, `SSR_IDX_IRQ_CLR);

	// Ones written to status or to the clear register drop flags
	assign clr_w = (wr_sts | wr_clr) ? (reg_wdata[15:0] & `SSR_EVT_MASK) : 16'h0000;

	// ----------------------------------------
	// Sticky event flags
	// ----------------------------------------
	// A new event in the clearing cycle keeps its flag set
	always_ff @(posedge clk) begin
		if (!rstn) begin
			button_pressed_flag_q <= 1'b0;
		end else if (ev_button) begin
			button_pressed_flag_q <= 1'b1;
		end else if (clr_w[`SSR_STS_BUTTON]) begin
			button_pressed_flag_q <= 1'b0;
		end
	end

	// Power fault flag
	always_ff @(posedge clk) begin
		if (!rstn) begin
			power_fault_flag_q <= 1'b0;
		end else if (ev_pfault) begin
			power_fault_flag_q <= 1'b1;
		end else if (clr_w[`SSR_STS_PFAULT]) begin
			power_fault_flag_q <= 1'b0;
		end
	end

	// Latch sensor change flag
	always_ff @(posedge clk) begin
		if (!rstn) begin
			latch_sensor_changed_flag_q <= 1'b0;
		end else if (ev_latch) begin
			latch_sensor_changed_flag_q <= 1'b1;
		end else if (clr_w[`SSR_STS_LATCH_CHG]) begin
			latch_sensor_changed_flag_q <= 1'b0;
		end
	end

	// Presence change flag
	always_ff @(posedge clk) begin
		if (!rstn) begin
			presence_changed_flag_q <= 1'b0;
		end else if (ev_pres) begin
			presence_changed_flag_q <= 1'b1;
		end else if (clr_w[`SSR_STS_PRES_CHG]) begin
			presence_changed_flag_q <= 1'b0;
		end
	end

	// Command completed flag stays set until cleared by a write of one
	always_ff @(posedge clk) begin
		if (!rstn) begin
			cmd_done_flag_q <= 1'b0;
		end else if (cmd_done) begin
			cmd_done_flag_q <= 1'b1;
		end else if (clr_w[`SSR_STS_CMD_DONE]) begin
			cmd_done_flag_q <= 1'b0;
		end
	end

	// Link active change flag
	always_ff @(posedge clk) begin
		if (!rstn) begin
			link_active_changed_flag_q <= 1'b0;
		end else if (ev_link) begin
			link_active_changed_flag_q <= 1'b1;
		end else if (clr_w[`SSR_STS_LINK_CHG]) begin
			link_active_changed_flag_q <= 1'b0;
		end
	end

	// Status word; bits 15:9 stay zero
	always_comb begin
		status_w = 16'h0000;
		status_w[`SSR_STS_BUTTON] = button_pressed_flag_q;
		status_w[`SSR_STS_PFAULT] = power_fault_flag_q;
		status_w[`SSR_STS_LATCH_CHG] = latch_sensor_changed_flag_q;
		status_w[`SSR_STS_PRES_CHG] = presence_changed_flag_q;
		status_w[`SSR_STS_CMD_DONE] = cmd_done_flag_q;
		status_w[`SSR_STS_LATCH] = latch_state_q;
		status_w[`SSR_STS_PRESENCE] = card_presence_state_q;
		status_w[`SSR_STS_INTERLOCK] = interlock_state_q;
		status_w[`SSR_STS_LINK_CHG] = link_active_changed_flag_q;
	end

	// ----------------------------------------
	// Slot control and command tracking
	// ----------------------------------------
	// Interlock control is a toggle request and never stored
	always_comb begin
		slot_control_d = reg_wdata[15:0] & `SSR_CTL_MASK;
		slot_control_d[`SSR_CTL_INTERLOCK] = 1'b0;
	end

	// Stores enables and actuator settings
	always_ff @(posedge clk) begin
		if (!rstn) begin
			slot_control_q <= `SSR_RST_SLOT_CTL;
		end else if (wr_ctl) begin
			slot_control_q <= slot_control_d;
		end
	end

	// Actuator fields that change, or an interlock toggle, need the expander
	assign need_xact = |((slot_control_d[`SSR_CTL_ACT_HI:`SSR_CTL_ACT_LO]
		^ slot_control_q[`SSR_CTL_ACT_HI:`SSR_CTL_ACT_LO])) | reg_wdata[`SSR_CTL_INTERLOCK];

	// Expander sees the settings including a pending interlock toggle
	always_ff @(posedge clk) begin
		if (!rstn) begin
			exp_ctl <= `SSR_RST_SLOT_CTL;
		end else if (wr_ctl) begin
			exp_ctl <= {slot_control_d[15:12], reg_wdata[`SSR_CTL_INTERLOCK], slot_control_d[10:0]};
		end
	end

	// One write, one command, however many fields it touches
	ssr_cmd_tracker u_cmd (
		.clk(clk),
		.rstn(rstn),
		.start(wr_ctl),
		.need_xact(need_xact),
		.cmd_done(cmd_done),
		.busy(),
		.exp_req(exp_req),
		.exp_done(exp_done)
	);

	// ----------------------------------------
	// Alternative routing forwarding
	// ----------------------------------------
	// Supported only on a downstream port that has the feature
	assign alt_routing_forward_supported = DOWNSTREAM & ARI_SUPPORT;

	// Enable is writable only where supported
	always_ff @(posedge clk) begin
		if (!rstn) begin
			alt_routing_forward_enable_q <= 1'b0;
		end else if (!alt_routing_forward_supported) begin
			alt_routing_forward_enable_q <= 1'b0;
		end else if (reg_wr && hit(reg_addr, `SSR_IDX_DEV_CTL2)) begin
			alt_routing_forward_enable_q <= reg_wdata[`SSR_ARI_BIT];
		end
	end

	// Device number check on type 1 to type 0 conversion
	assign skip_devnum_check = alt_routing_forward_enable_q;
	assign cfg_dev_ok = alt_routing_forward_enable_q | (cfg_dev_num == 5'h00);

	// ----------------------------------------
	// Interrupt
	// ----------------------------------------
	// Enable register of status layout, cleared flags by write of one
	always_ff @(posedge clk) begin
		if (!rstn) begin
			irq_en_q <= `SSR_RST_IRQ_EN;
		end else if (reg_wr && hit(reg_addr, `SSR_IDX_IRQ_EN)) begin
			irq_en_q <= reg_wdata[15:0] & `SSR_EVT_MASK;
		end
	end

	// Level output, gated by the master hot-plug enable
	assign hotplug_irq = slot_control_q[`SSR_CTL_MASTER_EN]
		& |(status_w & irq_en_q & `SSR_EVT_MASK);

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	// Unmapped and write-only addresses read as zero
	always_comb begin
		rdata_d = 32'h0000_0000;
		if (hit(reg_addr, `SSR_IDX_SLOT_CTL)) begin
			rdata_d[15:0] = slot_control_q;
		end else if (hit(reg_addr, `SSR_IDX_SLOT_STS)) begin
			rdata_d[15:0] = status_w;
		end else if (hit(reg_addr, `SSR_IDX_DEV_CAP2)) begin
			rdata_d[`SSR_ARI_BIT] = alt_routing_forward_supported;
		end else if (hit(reg_addr, `SSR_IDX_DEV_CTL2)) begin
			rdata_d[`SSR_ARI_BIT] = alt_routing_forward_enable_q;
		end else if (hit(reg_addr, `SSR_IDX_IRQ_EN)) begin
			rdata_d[15:0] = irq_en_q;
		end
	end

	// Read data stand in the cycle after the strobe only
	always_ff @(posedge clk) begin
		if (!rstn) begin
			rdata_q <= 32'h0000_0000;
		end else if (reg_rd) begin
			rdata_q <= rdata_d;
		end else begin
			rdata_q <= 32'h0000_0000;
		end
	end

	assign reg_rdata = rdata_q;

endmodule // ssr_regs
